// File: hdl/ltb_defs.svh
`ifndef LTB_DEFS_SVH
`define LTB_DEFS_SVH
// ****************************************
// opcode upper bits and table field codes
// ****************************************
`define LTB_OP_ADD     8'h0F
`define LTB_OP_AND     8'h0B
`define LTB_OP_IOR     8'h09
`define LTB_OP_XOR     8'h0A
`define LTB_OP_SUB     8'h08
`define LTB_OP_LOAD_LITERAL_TO_WORK   8'h0E
`define LTB_OP_MUL     8'h0D
`define LTB_OP_RETURN_WITH_LITERAL   8'h0C
`define LTB_OP_LOAD_BANK_SELECT_LITERAL   12'h010
`define LTB_OP_BZ      8'hE0
`define LTB_OP_LOAD_POINTER_LITERAL    10'h3B8
`define LTB_OP_LFSR2   8'hF0
`define LTB_OP_CALL    7'h76
`define LTB_OP_WORD2   4'hF
`define LTB_OP_TBL     12'h000
`define LTB_TBL_RD     2'h2
`define LTB_TBL_WR     2'h3
`define LTB_TBL_NONE   2'h0
`define LTB_TBL_POSTI  2'h1
`define LTB_TBL_POSTD  2'h2
`define LTB_TBL_PREI   2'h3
// ****************************************
// status bit positions and reset values
// ****************************************
`define LTB_ST_C       0
`define LTB_ST_DC      1
`define LTB_ST_Z       2
`define LTB_ST_OV      3
`define LTB_ST_N       4
`define LTB_PC_RST     21'h000000
`define LTB_PC_STEP    21'h000002
`define LTB_PTR_STEP   21'h000001
`define LTB_FSR_CNT    3
`endif

// File: hdl/ltb_pkg.sv
package ltb_pkg;
  typedef enum logic [2:0] {
    LTB_ST_EXEC  = 3'h1,
    LTB_ST_FLUSH = 3'h2,
    LTB_ST_WORD2 = 3'h4
  } ltb_state_e;
  typedef enum logic [2:0] {
    LTB_ALU_ADD, LTB_ALU_AND, LTB_ALU_IOR, LTB_ALU_XOR,
    LTB_ALU_SUB, LTB_ALU_MOV, LTB_ALU_MUL
  } ltb_alu_op_e;
endpackage : ltb_pkg

// File: hdl/ltb_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ltb_alu_if;
  ltb_pkg::ltb_alu_op_e op;
  logic [7:0]           lit;
  logic [7:0]           work;
  logic [4:0]           flags_in;
  logic [7:0]           result;
  logic [4:0]           flags_out;
  logic [15:0]          product;
  modport core (output op, lit, work, flags_in,
                input  result, flags_out, product);
  modport alu  (input  op, lit, work, flags_in,
                output result, flags_out, product);
endinterface : ltb_alu_if
`default_nettype wire

// File: hdl/ltb_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "ltb_defs.svh"
module ltb_alu (
  ltb_alu_if.alu a
);
  logic [8:0] sum;
  logic [4:0] nib;
  always_comb begin
    sum         = 9'h000;
    nib         = 5'h00;
    a.result    = a.work;
    a.flags_out = a.flags_in;
    a.product   = {8'h00, a.lit} * {8'h00, a.work};
    case (a.op)
      ltb_pkg::LTB_ALU_ADD: begin
        sum      = {1'b0, a.work} + {1'b0, a.lit};
        nib      = {1'b0, a.work[3:0]} + {1'b0, a.lit[3:0]};
        a.result = sum[7:0];
        a.flags_out[`LTB_ST_C]  = sum[8];
        a.flags_out[`LTB_ST_DC] = nib[4];
        a.flags_out[`LTB_ST_OV] = (a.work[7] == a.lit[7]) &&
                                  (sum[7] != a.lit[7]);
      end
      ltb_pkg::LTB_ALU_SUB: begin
        // carry reads as no-borrow
        sum      = {1'b0, a.lit} + {1'b0, ~a.work} + 9'h001;
        nib      = {1'b0, a.lit[3:0]} + {1'b0, ~a.work[3:0]} + 5'h01;
        a.result = sum[7:0];
        a.flags_out[`LTB_ST_C]  = sum[8];
        a.flags_out[`LTB_ST_DC] = nib[4];
        a.flags_out[`LTB_ST_OV] = (a.work[7] != a.lit[7]) &&
                                  (sum[7] != a.lit[7]);
      end
      ltb_pkg::LTB_ALU_AND: a.result = a.lit & a.work;
      ltb_pkg::LTB_ALU_IOR: a.result = a.lit | a.work;
      ltb_pkg::LTB_ALU_XOR: a.result = a.lit ^ a.work;
      ltb_pkg::LTB_ALU_MOV: a.result = a.lit;
      default:              a.result = a.work;
    endcase
    if (a.op != ltb_pkg::LTB_ALU_MOV && a.op != ltb_pkg::LTB_ALU_MUL) begin
      a.flags_out[`LTB_ST_Z] = (a.result == 8'h00);
      a.flags_out[`LTB_ST_N] = a.result[7];
    end
  end
endmodule : ltb_alu
`default_nettype wire

// File: hdl/ltb_decoder.sv
// Operation
// - literal add into work register, one cycle, flags C DC Z OV N
// - literal and, or, xor with work, one cycle, only Z and N
// - literal minus work into work, one cycle, flags C DC Z OV N
// - literal load and literal multiply, one cycle, flags untouched
// - four-bit literal into low bank select bits, one cycle
// - literal into work plus subroutine return, two cycles, no flags
// - pointer load is two words, two cycles, twelve-bit value
// - table read, two cycles, four pointer update variants
// - table write, two cycles, four pointer update variants
// - port read-modify-write uses the pin level, not the latch
// - timer zero count write clears its prescaler when assigned
// - program counter change or true test costs a nop cycle
// - lone second word runs as a nop
// - call: two words, pushes pc+4, loads twenty-bit target
`timescale 1ns/1ps
`default_nettype none
`include "ltb_defs.svh"
module ltb_decoder #(
  parameter int STACK_DEPTH = 31
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // program memory
  input  wire logic [15:0] instr_in,
  output logic      [20:0] pc_out,
  // table access
  input  wire logic [7:0]  tbl_rdata_in,
  output logic      [20:0] tbl_addr_out,
  output logic             tbl_rd_out,
  output logic             tbl_wr_out,
  output logic      [7:0]  tablat_out,
  // port and timer side
  input  wire logic [7:0]  port_pins_in,
  input  wire logic        timer_zero_count_write_in,
  input  wire logic        prescaler_assigned_in,
  output logic      [7:0]  port_operand_out,
  output logic             prescaler_clear_out,
  // core state
  output logic      [7:0]  working_register_out,
  output logic      [4:0]  status_out,
  output logic      [3:0]  bank_select_register_out,
  output logic      [35:0] file_select_pointer_out,
  output logic      [15:0] product_out,
  output logic      [7:0]  work_shadow_out,
  output logic      [4:0]  flags_shadow_out,
  output logic      [3:0]  bank_shadow_out,
  output logic      [4:0]  stack_ptr_out
);
  // ****************************************
  // state
  // ****************************************
  ltb_pkg::ltb_state_e state_r, state_nxt;
  logic [20:0] pc_r, pc_nxt, tblptr_r, tblptr_nxt, tbl_addr_r, tbl_addr_nxt;
  logic [7:0]  w_r, w_nxt, ws_r, ws_nxt, tablat_r, tablat_nxt;
  logic [4:0]  st_r, st_nxt, ss_r, ss_nxt, sp_r, sp_nxt;
  logic [3:0]  bsr_r, bsr_nxt, bs_r, bs_nxt;
  logic [15:0] prod_r, prod_nxt, op1_r, op1_nxt;
  logic        tbl_rd_r, tbl_rd_nxt, tbl_wr_r, tbl_wr_nxt;
  logic [11:0] fsr_r [`LTB_FSR_CNT];
  logic [11:0] fsr_nxt [`LTB_FSR_CNT];
  logic [20:0] stk_r [STACK_DEPTH];
  logic        push, pop;
  logic [20:0] return_stack_top;
  logic [7:0]  pin_meta_r, pin_sync_r;
  ltb_alu_if   alu_bus ();

  ltb_alu u_alu (
    .a (alu_bus.alu)
  );

  assign return_stack_top = (sp_r == 5'h00) ? `LTB_PC_RST : stk_r[sp_r - 5'h01];
  assign alu_bus.lit      = instr_in[7:0];
  assign alu_bus.work     = w_r;
  assign alu_bus.flags_in = st_r;

  // ****************************************
  // decode and execute
  // ****************************************
  always_comb begin
    state_nxt    = ltb_pkg::LTB_ST_EXEC;
    pc_nxt       = pc_r + `LTB_PC_STEP;
    w_nxt        = w_r;
    st_nxt       = st_r;
    bsr_nxt      = bsr_r;
    prod_nxt     = prod_r;
    ws_nxt       = ws_r;
    ss_nxt       = ss_r;
    bs_nxt       = bs_r;
    op1_nxt      = op1_r;
    tblptr_nxt   = tblptr_r;
    tbl_addr_nxt = tbl_addr_r;
    tbl_rd_nxt   = 1'b0;
    tbl_wr_nxt   = 1'b0;
    tablat_nxt   = tablat_r;
    push         = 1'b0;
    pop          = 1'b0;
    alu_bus.op   = ltb_pkg::LTB_ALU_MOV;
    for (int i = 0; i < `LTB_FSR_CNT; i++) begin
      fsr_nxt[i] = fsr_r[i];
    end
    case (state_r)
      ltb_pkg::LTB_ST_EXEC: begin
        case (instr_in[15:8])
          `LTB_OP_ADD: alu_bus.op = ltb_pkg::LTB_ALU_ADD;
          `LTB_OP_AND: alu_bus.op = ltb_pkg::LTB_ALU_AND;
          `LTB_OP_IOR: alu_bus.op = ltb_pkg::LTB_ALU_IOR;
          `LTB_OP_XOR: alu_bus.op = ltb_pkg::LTB_ALU_XOR;
          `LTB_OP_SUB: alu_bus.op = ltb_pkg::LTB_ALU_SUB;
          `LTB_OP_MUL: alu_bus.op = ltb_pkg::LTB_ALU_MUL;
          default:     alu_bus.op = ltb_pkg::LTB_ALU_MOV;
        endcase
        case (instr_in[15:8])
          `LTB_OP_ADD, `LTB_OP_AND, `LTB_OP_IOR, `LTB_OP_XOR,
          `LTB_OP_SUB, `LTB_OP_LOAD_LITERAL_TO_WORK: begin
            w_nxt  = alu_bus.result;
            st_nxt = alu_bus.flags_out;
          end
          `LTB_OP_MUL: prod_nxt = alu_bus.product;
          `LTB_OP_RETURN_WITH_LITERAL: begin
            w_nxt     = alu_bus.result;
            pop       = 1'b1;
            pc_nxt    = return_stack_top;
            state_nxt = ltb_pkg::LTB_ST_FLUSH;
          end
          `LTB_OP_BZ: begin
            if (st_r[`LTB_ST_Z]) begin
              pc_nxt    = pc_r + `LTB_PC_STEP +
                          {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
              state_nxt = ltb_pkg::LTB_ST_FLUSH;
            end
          end
          default: begin
            if (instr_in[15:4] == `LTB_OP_LOAD_BANK_SELECT_LITERAL) begin
              bsr_nxt = instr_in[3:0];
            end else if (instr_in[15:6] == `LTB_OP_LOAD_POINTER_LITERAL ||
                         instr_in[15:9] == `LTB_OP_CALL) begin
              op1_nxt   = instr_in;
              state_nxt = ltb_pkg::LTB_ST_WORD2;
            end else if (instr_in[15:4] == `LTB_OP_TBL &&
                         instr_in[3]) begin
              tbl_rd_nxt   = (instr_in[3:2] == `LTB_TBL_RD);
              tbl_wr_nxt   = (instr_in[3:2] == `LTB_TBL_WR);
              tbl_addr_nxt = tblptr_r;
              case (instr_in[1:0])
                `LTB_TBL_POSTI: tblptr_nxt = tblptr_r + `LTB_PTR_STEP;
                `LTB_TBL_POSTD: tblptr_nxt = tblptr_r - `LTB_PTR_STEP;
                `LTB_TBL_PREI: begin
                  tblptr_nxt   = tblptr_r + `LTB_PTR_STEP;
                  tbl_addr_nxt = tblptr_r + `LTB_PTR_STEP;
                end
                default:        tblptr_nxt = tblptr_r;
              endcase
              state_nxt = ltb_pkg::LTB_ST_FLUSH;
            end
            // a lone second word or any other word falls through as a nop
          end
        endcase
      end
      ltb_pkg::LTB_ST_WORD2: begin
        // second word is consumed only because the first word asked for it
        if (op1_r[15:9] == `LTB_OP_CALL) begin
          push   = 1'b1;
          pc_nxt = {instr_in[11:0], op1_r[7:0], 1'b0};
          if (op1_r[8]) begin
            ws_nxt = w_r;
            ss_nxt = st_r;
            bs_nxt = bsr_r;
          end
        end else if (op1_r[5:4] != 2'h3) begin
          fsr_nxt[op1_r[5:4]] = {op1_r[3:0], instr_in[7:0]};
        end
      end
      ltb_pkg::LTB_ST_FLUSH: begin
        pc_nxt = pc_r;
        if (tbl_rd_r) begin
          tablat_nxt = tbl_rdata_in;
        end
      end
      default: begin
        pc_nxt = pc_r;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= ltb_pkg::LTB_ST_EXEC;
      pc_r       <= `LTB_PC_RST;
      w_r        <= 8'h00;
      st_r       <= 5'h00;
      bsr_r      <= 4'h0;
      prod_r     <= 16'h0000;
      ws_r       <= 8'h00;
      ss_r       <= 5'h00;
      bs_r       <= 4'h0;
      op1_r      <= 16'h0000;
      tblptr_r   <= `LTB_PC_RST;
      tbl_addr_r <= `LTB_PC_RST;
      tbl_rd_r   <= 1'b0;
      tbl_wr_r   <= 1'b0;
      tablat_r   <= 8'h00;
      sp_r       <= 5'h00;
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
      for (int i = 0; i < `LTB_FSR_CNT; i++) begin
        fsr_r[i] <= 12'h000;
      end
    end else begin
      state_r    <= state_nxt;
      pc_r       <= pc_nxt;
      w_r        <= w_nxt;
      st_r       <= st_nxt;
      bsr_r      <= bsr_nxt;
      prod_r     <= prod_nxt;
      ws_r       <= ws_nxt;
      ss_r       <= ss_nxt;
      bs_r       <= bs_nxt;
      op1_r      <= op1_nxt;
      tblptr_r   <= tblptr_nxt;
      tbl_addr_r <= tbl_addr_nxt;
      tbl_rd_r   <= tbl_rd_nxt;
      tbl_wr_r   <= tbl_wr_nxt;
      tablat_r   <= tablat_nxt;
      sp_r       <= sp_nxt;
      pin_meta_r <= port_pins_in;
      pin_sync_r <= pin_meta_r;
      for (int i = 0; i < `LTB_FSR_CNT; i++) begin
        fsr_r[i] <= fsr_nxt[i];
      end
    end
  end

  // a full stack drops the push; an empty one returns to the reset vector
  always_comb begin
    sp_nxt = sp_r;
    if (push && sp_r != STACK_DEPTH[4:0]) begin
      sp_nxt = sp_r + 5'h01;
    end else if (pop && sp_r != 5'h00) begin
      sp_nxt = sp_r - 5'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push && sp_r != STACK_DEPTH[4:0]) begin
      stk_r[sp_r] <= pc_r + `LTB_PC_STEP;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pc_out                   = pc_r;
  assign tbl_addr_out             = tbl_addr_r;
  assign tbl_rd_out               = tbl_rd_r;
  assign tbl_wr_out               = tbl_wr_r;
  assign tablat_out               = tablat_r;
  assign port_operand_out         = pin_sync_r;
  assign prescaler_clear_out      = timer_zero_count_write_in &&
                                    prescaler_assigned_in;
  assign working_register_out     = w_r;
  assign status_out               = st_r;
  assign bank_select_register_out = bsr_r;
  assign file_select_pointer_out  = {fsr_r[2], fsr_r[1], fsr_r[0]};
  assign product_out              = prod_r;
  assign work_shadow_out          = ws_r;
  assign flags_shadow_out         = ss_r;
  assign bank_shadow_out          = bs_r;
  assign stack_ptr_out            = sp_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic ex;
  // the release edge still sees reset, so no instruction is taken there
  assign ex = rst_n_in && (state_r == ltb_pkg::LTB_ST_EXEC);

  sequence s_nop_cycle;
    state_r == ltb_pkg::LTB_ST_FLUSH ##1 state_r == ltb_pkg::LTB_ST_EXEC;
  endsequence

  property p_add;
    ex && instr_in[15:8] == `LTB_OP_ADD |=>
      w_r == $past(w_r + instr_in[7:0]);
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_and;
    ex && instr_in[15:8] == `LTB_OP_AND |=>
      w_r == $past(w_r & instr_in[7:0]) && $stable(st_r[`LTB_ST_C]);
  endproperty
  a_and: assert property (p_and) else $error("and wrong");
  property p_sub;
    ex && instr_in[15:8] == `LTB_OP_SUB |=>
      w_r == $past(instr_in[7:0] - w_r);
  endproperty
  a_sub: assert property (p_sub) else $error("subtract wrong");
  property p_load_literal_to_work;
    ex && instr_in[15:8] == `LTB_OP_LOAD_LITERAL_TO_WORK |=>
      w_r == $past(instr_in[7:0]) && $stable(st_r);
  endproperty
  a_load_literal_to_work: assert property (p_load_literal_to_work) else $error("load wrong");
  property p_load_bank_select_literal;
    ex && instr_in[15:4] == `LTB_OP_LOAD_BANK_SELECT_LITERAL |=>
      bsr_r == $past(instr_in[3:0]) && $stable(st_r);
  endproperty
  a_load_bank_select_literal: assert property (p_load_bank_select_literal) else $error("bank wrong");
  property p_return_with_literal;
    ex && instr_in[15:8] == `LTB_OP_RETURN_WITH_LITERAL |=>
      pc_r == $past(return_stack_top) ##0 s_nop_cycle;
  endproperty
  a_return_with_literal: assert property (p_return_with_literal) else $error("return wrong");
  property p_bz;
    ex && instr_in[15:8] == `LTB_OP_BZ && st_r[`LTB_ST_Z] |=>
      s_nop_cycle ##0 $stable(pc_r);
  endproperty
  a_bz: assert property (p_bz) else $error("branch not two cycles");
  property p_lone;
    ex && instr_in[15:12] == `LTB_OP_WORD2 |=>
      $stable(w_r) && pc_r == $past(pc_r) + `LTB_PC_STEP;
  endproperty
  a_lone: assert property (p_lone) else $error("lone word acted");
  property p_call;
    state_r == ltb_pkg::LTB_ST_WORD2 && op1_r[15:9] == `LTB_OP_CALL |=>
      pc_r == {$past(instr_in[11:0]), $past(op1_r[7:0]), 1'b0};
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_tblpost;
    ex && instr_in == {`LTB_OP_TBL, `LTB_TBL_RD, `LTB_TBL_POSTI} |=>
      tbl_rd_r && tbl_addr_r == $past(tblptr_r) &&
      tblptr_r == $past(tblptr_r) + `LTB_PTR_STEP;
  endproperty
  a_tblpost: assert property (p_tblpost) else $error("table ptr wrong");
endmodule : ltb_decoder
`default_nettype wire

// File: dv/ltb_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// program memory and table data model
// ****************************************
module ltb_prog_mem (
  // fetch side
  input  wire logic [20:0] pc_in,
  output logic      [15:0] instr_out,
  // table side
  input  wire logic [20:0] tbl_addr_in,
  output logic      [7:0]  tbl_rdata_out
);
  logic [15:0] mem [0:1023];

  // words past the array read as nop, like blank flash
  assign instr_out = (pc_in[20:11] == 10'h000) ? mem[pc_in[10:1]] : 16'h0000;
  // data follows the address, so a stale capture shows up
  assign tbl_rdata_out = tbl_addr_in[7:0] ^ 8'h5A;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'h0000;
    end
  end
endmodule : ltb_prog_mem
`default_nettype wire

// File: dv/literal_table_branch_call_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module literal_table_branch_call_decoder_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic        clk_in;
  logic        rst_n_in;
  logic [15:0] instr;
  logic [20:0] pc;
  logic [7:0]  rdata;
  logic [20:0] taddr;
  logic        trd;
  logic        twr;
  logic [7:0]  tablat;
  logic [7:0]  pins;
  logic        tmr_wr;
  logic        pre_as;
  logic [7:0]  port_op;
  logic        pre_clr;
  logic [7:0]  w;
  logic [4:0]  st;
  logic [3:0]  bank_select_register;
  logic [35:0] file_select_pointer;
  logic [15:0] prod;
  logic [7:0]  ws;
  logic [4:0]  sts;
  logic [3:0]  bs;
  logic [4:0]  sp;
  int          fails;
  int          samples_checked;

  ltb_prog_mem pm (.pc_in(pc), .instr_out(instr), .tbl_addr_in(taddr),
    .tbl_rdata_out(rdata));

  ltb_decoder uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr),
    .pc_out(pc), .tbl_rdata_in(rdata), .tbl_addr_out(taddr),
    .tbl_rd_out(trd), .tbl_wr_out(twr), .tablat_out(tablat),
    .port_pins_in(pins), .timer_zero_count_write_in(tmr_wr),
    .prescaler_assigned_in(pre_as), .port_operand_out(port_op),
    .prescaler_clear_out(pre_clr), .working_register_out(w),
    .status_out(st), .bank_select_register_out(bank_select_register),
    .file_select_pointer_out(file_select_pointer), .product_out(prod),
    .work_shadow_out(ws), .flags_shadow_out(sts), .bank_shadow_out(bs),
    .stack_ptr_out(sp));

  initial clk_in = 1'b0;
  always #12.5 clk_in = ~clk_in;

  // ****************************************
  // helpers
  // ****************************************
  task check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // memory is only reloaded while the core is held in reset
  task rst_on;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    for (int i = 0; i < 1024; i++) begin
      pm.mem[i] = 16'h0000;
    end
  endtask : rst_on

  task go;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask : go

  task tick;
    @(posedge clk_in);
    #1;
  endtask : tick

  // ****************************************
  // scenarios
  // ****************************************
  task t_literal;
    logic [15:0] op [0:9];
    logic [7:0]  ew [0:9];
    logic [4:0]  es [0:9];
    op = '{16'h0E55, 16'h0FAB, 16'h0E80, 16'h0B0F, 16'h09F0, 16'h0AF0,
           16'h0E03, 16'h0801, 16'h0D05, 16'h0107};
    ew = '{8'h55, 8'h00, 8'h80, 8'h00, 8'hF0, 8'h00, 8'h03, 8'hFE,
           8'hFE, 8'hFE};
    es = '{5'h00, 5'h07, 5'h07, 5'h07, 5'h13, 5'h07, 5'h07, 5'h10,
           5'h10, 5'h10};
    rst_on();
    for (int i = 0; i < 10; i++) begin
      pm.mem[i] = op[i];
    end
    go();
    for (int i = 0; i < 10; i++) begin
      tick();
      check(w, ew[i]);
      check(st, es[i]);
    end
    check(prod, 36'h04F6);
    check(bank_select_register, 36'h7);
    check(pc, 36'h14);
    $display("test literal done");
  endtask : t_literal

  task t_branch;
    rst_on();
    pm.mem[0] = 16'h0F00;
    pm.mem[1] = 16'hE003;
    pm.mem[2] = 16'h0E11;
    pm.mem[5] = 16'h0E22;
    pm.mem[6] = 16'h0F01;
    pm.mem[7] = 16'hE0FE;
    go();
    tick();
    check(st, 36'h04);
    tick();
    check(pc, 36'h0A);
    tick();
    check(pc, 36'h0A);
    check(w, 36'h00);
    tick();
    check(w, 36'h22);
    tick();
    check(st, 36'h00);
    tick();
    check(pc, 36'h10);
    tick();
    check(pc, 36'h12);
    $display("test branch done");
  endtask : t_branch

  task t_call;
    rst_on();
    pm.mem[0] = 16'h0FA6;
    pm.mem[1] = 16'h0103;
    pm.mem[2] = 16'hED34;
    pm.mem[3] = 16'hF001;
    pm.mem[4] = 16'hEC00;
    pm.mem[5] = 16'hF001;
    pm.mem[10'h134] = 16'h0C77;
    pm.mem[10'h100] = 16'hF0FF;
    go();
    repeat (3) tick();
    check(pc, 36'h6);
    tick();
    check(pc, 36'h268);
    check(sp, 36'h1);
    check({ws, sts, bs}, {19'h0, 8'hA6, 5'h10, 4'h3});
    tick();
    check(w, 36'h77);
    check(pc, 36'h8);
    check(sp, 36'h0);
    tick();
    check(pc, 36'h8);
    tick();
    check(pc, 36'hA);
    tick();
    check(pc, 36'h200);
    check({ws, sp}, {23'h0, 8'hA6, 5'h1});
    tick();
    check(pc, 36'h202);
    check(w, 36'h77);
    $display("test call done");
  endtask : t_call

  task t_pointer;
    rst_on();
    pm.mem[0] = 16'hEE01;
    pm.mem[1] = 16'hF023;
    pm.mem[2] = 16'hEE1A;
    pm.mem[3] = 16'hF0BC;
    pm.mem[4] = 16'hEE25;
    pm.mem[5] = 16'hF0C3;
    go();
    repeat (2) tick();
    check(file_select_pointer, 36'h000000123);
    repeat (4) tick();
    check(file_select_pointer, 36'h5C3ABC123);
    check(pc, 36'h0C);
    $display("test pointer done");
  endtask : t_pointer

  task t_table;
    logic [15:0] op [0:7];
    logic [20:0] ea [0:7];
    op = '{16'h0009, 16'h000B, 16'h000A, 16'h0008, 16'h000F, 16'h000D,
           16'h000E, 16'h000C};
    ea = '{21'h0, 21'h2, 21'h2, 21'h1, 21'h2, 21'h2, 21'h3, 21'h2};
    rst_on();
    for (int i = 0; i < 8; i++) begin
      pm.mem[i] = op[i];
    end
    go();
    for (int i = 0; i < 8; i++) begin
      tick();
      check({trd, twr}, (i < 4) ? 36'h2 : 36'h1);
      check(taddr, ea[i]);
      tick();
      check({trd, twr}, 36'h0);
      if (i < 4) begin
        check(tablat, ea[i][7:0] ^ 8'h5A);
      end
    end
    $display("test table done");
  endtask : t_table

  task t_port_timer;
    logic [7:0] pv [0:1];
    pv = '{8'hC3, 8'h3C};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      tmr_wr <= k[1];
      pre_as <= k[0];
      #1;
      check(pre_clr, k[1] & k[0]);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      pins <= pv[k];
      tick();
      check(port_op, (k == 0) ? 8'h00 : pv[0]);
      tick();
      check(port_op, pv[k]);
    end
    $display("test port timer done");
  endtask : t_port_timer

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rst_n_in = 1'b0;
    pins = 8'h00;
    tmr_wr = 1'b0;
    pre_as = 1'b0;
    fails = 0;
    samples_checked = 0;
    t_literal();
    t_branch();
    t_call();
    t_pointer();
    t_table();
    t_port_timer();
    final_report();
  end

  // the tests need well under a thousand cycles; this is eighty thousand
  initial begin
    #2000000;
    fails++;
    final_report();
  end
endmodule : literal_table_branch_call_decoder_tb_top
`default_nettype wire
